/* logic/rae_alarm_evaluator.sv */
// Per-relay alarm evaluation, relay drive and front-panel indicators.
`timescale 1ns/10ps
`include "rae_consts.svh"

module rae_alarm_evaluator #(
	parameter int NREL         = 2,
	parameter int SW           = `RAE_SAMPLE_BITS,
	parameter int STEP_CYCLES  = `RAE_DELAY_STEP_MS * `RAE_CLK_KHZ,
	parameter int FLASH_CYCLES = `RAE_FLASH_MS * `RAE_CLK_KHZ,
	parameter int BLINK_CYCLES = `RAE_BLINK_MS * `RAE_CLK_KHZ,
	parameter int SB           = $clog2(`RAE_DELAY_MAX_STEPS + 1)
) (
	input  wire logic                  clk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic signed [SW-1:0]  sample_i,
	input  wire logic                  sample_valid_i,
	input  wire logic                  open_sensor_i,
	input  wire logic                  lead_break_i,
	input  wire logic                  over_range_i,
	input  wire logic                  under_range_i,
	input  wire logic                  diag_busy_i,
	input  wire logic                  diag_fail_i,
	input  rae_pkg::rae_func_type      func_i [NREL],
	input  wire logic                  limit_high_i [NREL],
	input  wire logic signed [SW-1:0]  sp_hi_i [NREL],
	input  wire logic signed [SW-1:0]  sp_lo_i [NREL],
	input  wire logic signed [SW-1:0]  deadband_i [NREL],
	input  wire logic [SB-1:0]         delay_steps_i [NREL],
	input  wire logic                  latch_en_i [NREL],
	input  wire logic                  failsafe_i [NREL],
	input  wire logic                  sw_reset_i [NREL],
	input  wire logic                  reset_btn_i [NREL],
	input  wire logic                  field_mode_i,
	input  wire logic                  capture_btn_i,
	input  wire logic                  field_edit_i [NREL],
	input  wire logic                  field_param2_i [NREL],
	input  wire logic                  host_configured_i,
	input  wire logic                  field_write_req_i,
	output logic                       field_write_ok_o,
	output logic                       alarm_o [NREL],
	output logic                       relay_coil_o [NREL],
	output logic                       relay_led_o [NREL],
	output logic                       run_led_o,
	output logic                       status_led_o
);
	import rae_pkg::*;

	localparam int WW = SW + 2;
	localparam int NS = `RAE_ROC_SAMPLES;
	localparam int FW = $clog2(FLASH_CYCLES + 1);
	localparam int BW = $clog2(BLINK_CYCLES + 1);

	if (NREL < 1 || NREL > 2 || SW < 4 || FLASH_CYCLES < 1 ||
	    BLINK_CYCLES < 1) begin : g_bad
		$error("rae_alarm_evaluator: unsupported parameter values");
	end

	// Sign-extends a sample so sums with a deadband cannot wrap.
	function automatic logic signed [WW-1:0] wide(
		input logic signed [SW-1:0] v);
		return signed'({{2{v[SW-1]}}, v});
	endfunction : wide

	// Magnitude of a widened difference.
	function automatic logic signed [WW-1:0] mag(
		input logic signed [WW-1:0] v);
		return v[WW-1] ? -v : v;
	endfunction : mag

	// Sample hold and history for the rate calculation.
	logic signed [SW-1:0] samp;
	logic signed [SW-1:0] next_samp;
	logic signed [SW-1:0] hist [NS];
	logic signed [SW-1:0] next_hist [NS];
	logic [2:0]           fill;
	logic [2:0]           next_fill;
	logic signed [WW-1:0] rate_abs;
	logic                 rate_ok;

	// Shifts a new sample in on each valid strobe.
	always_comb begin
		next_samp = samp;
		next_hist = hist;
		next_fill = fill;
		if (sample_valid_i) begin
			next_samp = sample_i;
			next_hist[0] = samp;
			for (int i = 1; i < NS; i++) begin
				next_hist[i] = hist[i-1];
			end
			if (fill != 3'(NS + 1)) begin
				next_fill = fill + 3'd1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			samp <= '0;
			hist <= '{default: '0};
			fill <= '0;
		end else begin
			samp <= next_samp;
			hist <= next_hist;
			fill <= next_fill;
		end
	end

	// change across five sample intervals
	// Sum of five deltas across 1 s equals newest minus oldest.
	// Five deltas need six real samples, else the oldest is a reset zero.
	assign rate_abs = mag(wide(samp) - wide(hist[NS-1]));
	assign rate_ok  = (fill == 3'(NS + 1));

	// Pin inputs pass three flops; a level counts once stages 2 and 3 agree.
	logic [NREL:0] pin_raw;
	logic [NREL:0] s1, s2, s3, lvl, lvl_d;
	logic [NREL:0] next_lvl;

	always_comb begin
		for (int i = 0; i < NREL; i++) begin
			pin_raw[i] = reset_btn_i[i];
		end
		pin_raw[NREL] = capture_btn_i;
		next_lvl = lvl;
		for (int i = 0; i <= NREL; i++) begin
			if (s2[i] == s3[i]) begin
				next_lvl[i] = s3[i];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s1    <= '0;
			s2    <= '0;
			s3    <= '0;
			lvl   <= '0;
			lvl_d <= '0;
		end else begin
			s1    <= pin_raw;
			s2    <= s1;
			s3    <= s2;
			lvl   <= next_lvl;
			lvl_d <= lvl;
		end
	end

	// Flash square wave and capture blink timer.
	logic [FW-1:0] flash_cnt, next_flash_cnt;
	logic          flash, next_flash;
	logic [BW-1:0] blink_cnt, next_blink_cnt;

	always_comb begin
		next_flash_cnt = flash_cnt + FW'(1);
		next_flash     = flash;
		if (flash_cnt == FW'(FLASH_CYCLES - 1)) begin
			next_flash_cnt = '0;
			next_flash     = !flash;
		end
		next_blink_cnt = blink_cnt;
		if (field_mode_i && lvl[NREL] && !lvl_d[NREL]) begin
			next_blink_cnt = BW'(BLINK_CYCLES);
		end else if (blink_cnt != '0) begin
			next_blink_cnt = blink_cnt - BW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			flash_cnt <= '0;
			flash     <= 1'b0;
			blink_cnt <= '0;
		end else begin
			flash_cnt <= next_flash_cnt;
			flash     <= next_flash;
			blink_cnt <= next_blink_cnt;
		end
	end

	assign field_write_ok_o = field_mode_i && host_configured_i &&
	                          field_write_req_i;

	// Panel LEDs shared by all relays.
	logic next_run_led, next_status_led, fault;

	always_comb begin
		fault = open_sensor_i || lead_break_i || over_range_i ||
		        under_range_i;
		if (field_mode_i) begin
			next_run_led    = 1'b0;
			next_status_led = (blink_cnt != '0);
		end else begin
			next_run_led    = (diag_busy_i || diag_fail_i) ? flash : 1'b1;
			next_status_led = fault && flash;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			run_led_o    <= 1'b0;
			status_led_o <= 1'b0;
		end else begin
			run_led_o    <= next_run_led;
			status_led_o <= next_status_led;
		end
	end

	for (genvar g = 0; g < NREL; g++) begin : g_rel
		logic                 alarm, next_alarm;
		rae_pv_type           pv, next_pv;
		logic signed [SW-1:0] ext, next_ext;
		logic signed [WW-1:0] x, hi, lo, db;
		logic                 peak, enter_c, leave_c, enter_d, leave_d;
		logic                 reset_req, coil, led;

		// Entry and exit conditions for the selected function.
		always_comb begin
			x       = wide(samp);
			hi      = wide(sp_hi_i[g]);
			lo      = wide(sp_lo_i[g]);
			db      = wide(deadband_i[g]);
			peak    = (sp_hi_i[g] > sp_lo_i[g]);
			enter_c = 1'b0;
			leave_c = 1'b0;
			case (func_i[g])
				FUNC_LIMIT: begin
					if (limit_high_i[g]) begin
						enter_c = x > hi;
						leave_c = x <= hi - db;
					end else begin
						enter_c = x < lo;
						leave_c = x >= lo + db;
					end
				end
				FUNC_WINDOW: begin
					enter_c = (x > hi) || (x < lo);
					leave_c = (x <= hi - db) && (x >= lo + db);
				end
				FUNC_ONOFF: begin
					enter_c = x > hi;
					leave_c = x < lo;
				end
				FUNC_PEAK: enter_c = peak ? (x > hi) : (x < hi);
				default: ;
			endcase
			reset_req = lvl[g] || sw_reset_i[g];
		end

		rae_delay_timer #(
			.STEP_CYCLES (STEP_CYCLES),
			.MAX_STEPS   (`RAE_DELAY_MAX_STEPS),
			.SB          (SB)
		) u_enter (
			.clk_i     (clk_i),
			.sys_rst_i (sys_rst_i),
			.cond_i    (enter_c && !alarm && pv == PV_IDLE),
			.steps_i   (delay_steps_i[g]),
			.done_o    (enter_d)
		);

		rae_delay_timer #(
			.STEP_CYCLES (STEP_CYCLES),
			.MAX_STEPS   (`RAE_DELAY_MAX_STEPS),
			.SB          (SB)
		) u_leave (
			.clk_i     (clk_i),
			.sys_rst_i (sys_rst_i),
			.cond_i    (leave_c && alarm),
			.steps_i   (delay_steps_i[g]),
			.done_o    (leave_d)
		);

		// Alarm state per function.
		always_comb begin
			next_alarm = alarm;
			next_pv    = PV_IDLE;
			next_ext   = ext;
			case (func_i[g])
				FUNC_PEAK: begin
					next_pv = pv;
					case (pv)
						PV_IDLE: begin
							if (enter_d) begin
								next_pv  = PV_ARMED;
								next_ext = samp;
							end
						end
						PV_ARMED: begin
							if (peak ? (x > wide(ext)) : (x < wide(ext))) begin
								next_ext = samp;
							end
							if (peak ? (x <= wide(ext) - db)
							         : (x >= wide(ext) + db)) begin
								next_pv    = PV_ALARM;
								next_alarm = 1'b1;
							end
						end
						default: begin
							if (peak ? (x < lo) : (x > lo)) begin
								next_pv    = PV_IDLE;
								next_alarm = 1'b0;
							end
						end
					endcase
				end
				FUNC_ROC: begin
					if (rate_ok && rate_abs > hi) begin
						next_alarm = 1'b1;
					end else if (rate_abs < lo) begin
						next_alarm = 1'b0;
					end
				end
				default: begin
					if (!alarm && enter_d) begin
						next_alarm = 1'b1;
					end else if (alarm && leave_d && (!latch_en_i[g] ||
					             func_i[g] == FUNC_ONOFF || reset_req)) begin
						next_alarm = 1'b0;
					end
				end
			endcase
			coil = failsafe_i[g] ? !next_alarm : next_alarm;
			if (field_mode_i) begin
				led = field_edit_i[g] && (field_param2_i[g] ? flash : 1'b1);
			end else begin
				led = next_alarm;
			end
		end

		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				alarm           <= 1'b0;
				pv              <= PV_IDLE;
				ext             <= '0;
				relay_coil_o[g] <= 1'b0;
				relay_led_o[g]  <= 1'b0;
			end else begin
				alarm           <= next_alarm;
				pv              <= next_pv;
				ext             <= next_ext;
				relay_coil_o[g] <= coil;
				relay_led_o[g]  <= led;
			end
		end

		assign alarm_o[g] = alarm;

		// The coil is held low through reset, so the edge after release is skipped.
		property p_coil_pol;
			@(posedge clk_i) disable iff (sys_rst_i)
			!$past(sys_rst_i) |->
			relay_coil_o[g] == (failsafe_i[g] ? !alarm : alarm);
		endproperty
		a_coil_pol: assert property (p_coil_pol)
			else $error("Coil polarity does not follow alarm.");

		property p_onoff_nolatch;
			@(posedge clk_i) disable iff (sys_rst_i)
			(func_i[g] == FUNC_ONOFF && alarm && leave_d) |=> !alarm;
		endproperty
		a_onoff_nolatch: assert property (p_onoff_nolatch)
			else $error("On/off relay stayed latched.");

		property p_limit_entry;
			@(posedge clk_i) disable iff (sys_rst_i)
			(func_i[g] == FUNC_LIMIT && !alarm && !enter_d) |=> !alarm;
		endproperty
		a_limit_entry: assert property (p_limit_entry)
			else $error("Limit alarm set before the delay expired.");

		property p_latch_hold;
			@(posedge clk_i) disable iff (sys_rst_i)
			(func_i[g] inside {FUNC_LIMIT, FUNC_WINDOW} && latch_en_i[g] &&
			 alarm && !reset_req) |=> alarm;
		endproperty
		a_latch_hold: assert property (p_latch_hold)
			else $error("Latched relay left alarm without reset.");

		property p_pv_trip;
			@(posedge clk_i) disable iff (sys_rst_i)
			(func_i[g] == FUNC_PEAK && pv == PV_ARMED && peak &&
			 x <= wide(ext) - db) |=> (alarm && pv == PV_ALARM);
		endproperty
		a_pv_trip: assert property (p_pv_trip)
			else $error("Peak retreat did not alarm at once.");

		property p_pv_clear;
			@(posedge clk_i) disable iff (sys_rst_i)
			(func_i[g] == FUNC_PEAK && pv == PV_ALARM && !peak && x > lo)
			|=> !alarm;
		endproperty
		a_pv_clear: assert property (p_pv_clear)
			else $error("Valley alarm did not clear at deactivate.");

		property p_roc_trip;
			@(posedge clk_i) disable iff (sys_rst_i)
			(func_i[g] == FUNC_ROC && rate_ok && rate_abs > hi) |=> alarm;
		endproperty
		a_roc_trip: assert property (p_roc_trip)
			else $error("Rate alarm missed.");

		property p_led_alarm;
			@(posedge clk_i) disable iff (sys_rst_i)
			!field_mode_i |=> relay_led_o[g] == alarm;
		endproperty
		a_led_alarm: assert property (p_led_alarm)
			else $error("Relay LED does not show alarm.");
	end

	property p_field_run_off;
		@(posedge clk_i) disable iff (sys_rst_i)
		field_mode_i |=> !run_led_o;
	endproperty
	a_field_run_off: assert property (p_field_run_off)
		else $error("Run LED lit in field mode.");

	property p_run_steady;
		@(posedge clk_i) disable iff (sys_rst_i)
		(!sys_rst_i && !field_mode_i && !diag_busy_i && !diag_fail_i)
		|=> run_led_o;
	endproperty
	a_run_steady: assert property (p_run_steady)
		else $error("Run LED not steady in normal operation.");

	property p_field_gate;
		@(posedge clk_i) disable iff (sys_rst_i)
		field_write_ok_o |-> (host_configured_i && field_mode_i);
	endproperty
	a_field_gate: assert property (p_field_gate)
		else $error("Field edit allowed before host setup.");

endmodule : rae_alarm_evaluator

/* logic/rae_consts.svh */
// Timing figures and limits shared by the relay alarm evaluator files.
`ifndef RAE_CONSTS_SVH
`define RAE_CONSTS_SVH

// System clock rate in kHz (50 MHz, 20 ns period).
`define RAE_CLK_KHZ 50000
// One step of the relay delay, in milliseconds.
`define RAE_DELAY_STEP_MS 200
// Largest relay delay in steps (4 seconds of 200 ms steps).
`define RAE_DELAY_MAX_STEPS 20
// Half period of the LED flash, in milliseconds.
`define RAE_FLASH_MS 250
// Length of the status LED blink on a capture press, in milliseconds.
`define RAE_BLINK_MS 100
// Samples that span the rate-of-change interval of 1 second.
`define RAE_ROC_SAMPLES 5
// Default sample width in bits.
`define RAE_SAMPLE_BITS 16

`endif

/* logic/rae_delay_timer.sv */
// Qualifying delay timer that counts 200 ms steps while a condition holds.
`timescale 1ns/10ps
`include "rae_consts.svh"

module rae_delay_timer #(
	parameter int STEP_CYCLES = `RAE_DELAY_STEP_MS * `RAE_CLK_KHZ,
	parameter int MAX_STEPS   = `RAE_DELAY_MAX_STEPS,
	parameter int SB          = $clog2(MAX_STEPS + 1)
) (
	input  wire logic          clk_i,
	input  wire logic          sys_rst_i,
	input  wire logic          cond_i,
	input  wire logic [SB-1:0] steps_i,
	output logic               done_o
);
	localparam int CW = $clog2(STEP_CYCLES + 1);

	logic [CW-1:0] cyc;
	logic [CW-1:0] next_cyc;
	logic [SB-1:0] stp;
	logic [SB-1:0] next_stp;
	logic [SB-1:0] lim;

	if (STEP_CYCLES < 1 || MAX_STEPS < 1 || MAX_STEPS >= (1 << SB))
	begin : g_bad
		$error("rae_delay_timer: step length and count must be positive");
	end

	// clamp to four seconds
	// A request beyond the largest step count is served as the largest.
	assign lim = (steps_i > SB'(MAX_STEPS)) ? SB'(MAX_STEPS) : steps_i;

	// Counts whole steps; holds once the requested count is reached.
	always_comb begin
		next_cyc = cyc;
		next_stp = stp;
		if (!cond_i) begin
			next_cyc = '0;
			next_stp = '0;
		end else if (stp < lim) begin
			if (cyc == CW'(STEP_CYCLES - 1)) begin
				next_cyc = '0;
				next_stp = stp + SB'(1);
			end else begin
				next_cyc = cyc + CW'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cyc <= '0;
			stp <= '0;
		end else begin
			cyc <= next_cyc;
			stp <= next_stp;
		end
	end

	assign done_o = cond_i && (stp >= lim);

	property p_restart;
		@(posedge clk_i) disable iff (sys_rst_i)
		!cond_i |=> (stp == '0 && cyc == '0);
	endproperty
	a_restart: assert property (p_restart)
		else $error("Delay timer did not restart after lapse.");

	property p_delay_held;
		@(posedge clk_i) disable iff (sys_rst_i)
		(done_o && steps_i != '0) |-> $past(cond_i);
	endproperty
	a_delay_held: assert property (p_delay_held)
		else $error("Delay expired without the condition held.");

endmodule : rae_delay_timer

/* logic/rae_pkg.sv */
// Types shared by the relay alarm evaluator modules.
package rae_pkg;

	// Operating function selected for one relay.
	typedef enum logic [2:0] {
		FUNC_LIMIT,
		FUNC_WINDOW,
		FUNC_ONOFF,
		FUNC_PEAK,
		FUNC_ROC
	} rae_func_type;

	// Peak or valley detection progress of one relay.
	typedef enum logic [1:0] {
		PV_IDLE,
		PV_ARMED,
		PV_ALARM
	} rae_pv_type;

endpackage : rae_pkg

/* verification/rae_sample_src.sv */
// Sample source model that strobes a held input level at a fixed spacing.
`timescale 1ns/10ps
module rae_sample_src #(
	parameter int GAP = 10
) (
	input  wire logic               clk_i,
	input  wire logic               sys_rst_i,
	input  wire logic signed [15:0] level_i,
	output logic signed [15:0]      sample_o,
	output logic                    sample_valid_o
);
	int                 cnt;
	logic signed [15:0] held;

	always_ff @(posedge clk_i) begin
		cnt <= (sys_rst_i || cnt == GAP - 1) ? 0 : cnt + 1;
		sample_valid_o <= !sys_rst_i && cnt == GAP - 1;
		if (sys_rst_i) begin
			held <= 16'sh0000;
		end else if (cnt == GAP - 1) begin
			held <= level_i;
		end
	end

	// Off the strobe the line shows the inverse, so stale data never matches.
	assign sample_o = sample_valid_o ? held : ~held;
endmodule : rae_sample_src

/* verification/test_relay_alarm_evaluator.sv */
// Self-checking bench for the relay alarm evaluator.
`timescale 1ns/10ps
module test_relay_alarm_evaluator;
	import rae_pkg::*;

	localparam int PV[7] = '{150, 50, 150, 200, 189, 50, -1};
	localparam int CW[6] = '{121, 100, 101, -121, -100, -120};
	localparam int DL[2] = '{20, 3};

	logic               clk_i, sys_rst_i, sv, dbusy, dfail, fm;
	logic               cap, hc, wreq, wok, runl, stl, w_exp;
	logic signed [15:0] lvl, smp, hi[2], lo[2], db[2];
	logic [4:0]         ds[2];
	logic [3:0]         flt;
	logic               lh[2], le[2], fs[2], swr[2], rb[2];
	logic               fe[2], fp[2], al[2], coil[2], led[2];
	rae_func_type       fn[2];
	int                 n_mismatch, check_count, cyc_n;
	int                 seed = 5266;

	// Design with short step, flash and blink counts.
	rae_alarm_evaluator #(.STEP_CYCLES(4), .FLASH_CYCLES(4),
			.BLINK_CYCLES(3)) DUT (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sample_i(smp),
		.sample_valid_i(sv), .open_sensor_i(flt[0]),
		.lead_break_i(flt[1]), .over_range_i(flt[2]),
		.under_range_i(flt[3]), .diag_busy_i(dbusy),
		.diag_fail_i(dfail), .func_i(fn), .limit_high_i(lh),
		.sp_hi_i(hi), .sp_lo_i(lo), .deadband_i(db),
		.delay_steps_i(ds), .latch_en_i(le), .failsafe_i(fs),
		.sw_reset_i(swr), .reset_btn_i(rb), .field_mode_i(fm),
		.capture_btn_i(cap), .field_edit_i(fe),
		.field_param2_i(fp), .host_configured_i(hc),
		.field_write_req_i(wreq), .field_write_ok_o(wok),
		.alarm_o(al), .relay_coil_o(coil), .relay_led_o(led),
		.run_led_o(runl), .status_led_o(stl));

	// Far-side sample source, one strobe every ten cycles.
	rae_sample_src #(.GAP(10)) src (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .level_i(lvl), .sample_o(smp),
		.sample_valid_o(sv));

	// Window relay with setpoints 120 and -120 and a deadband of 20.
	function automatic logic win(input logic a, input logic signed [15:0] x);
		return (x > 16'sh78 || x < -16'sh78) ? 1'b1 :
			(x <= 16'sh64 && x >= -16'sh64) ? 1'b0 : a;
	endfunction : win

	// Prints the counts and the verdict, then stops.
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	// Compares one value and reports a difference.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Waits whole cycles and lands just after the edge.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc

	// Moves the input level, waits for it to be taken, then waits w cycles.
	task automatic go(input int v, input int w);
		@(posedge clk_i);
		lvl <= v[15:0];
		cyc(1);
		do cyc(0 + 1); while (sv !== 1'b1);
		cyc(1 + w);
	endtask : go

	// Sets relay one and resets the design so its history starts clean.
	task automatic cfg(input rae_func_type f, input int h, l, d, s,
			input logic t);
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		fn[0] <= f;
		hi[0] <= h[15:0];
		lo[0] <= l[15:0];
		db[0] <= d[15:0];
		ds[0] <= s[4:0];
		le[0] <= t;
		cyc(2);
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
	endtask : cfg

	// Drives the software reset (k even) or the reset button (k odd).
	task automatic rel(input logic v, input int k);
		@(posedge clk_i);
		swr[0] <= v & !k[0];
		rb[0] <= v & k[0];
	endtask : rel

	// Watches an LED for 12 cycles; result bit 1 saw on, bit 0 saw off.
	task automatic look(input int w, input logic [1:0] e);
		logic [1:0] s;
		s = 2'b00;
		repeat (12) begin
			cyc(1);
			s |= (w == 0 ? runl : w == 1 ? stl : led[w - 2]) ? 2'b10 : 2'b01;
		end
		chk(s, e);
	endtask : look

	// Clock of 20 ns.
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// Cycle ceiling and the window reference for relay two.
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 6000) begin
			n_mismatch++;
			end_sim();
		end
		w_exp <= sys_rst_i ? 1'b0 : sv ? win(w_exp, smp) : w_exp;
	end

	// Main sequence of scenarios.
	initial begin
		sys_rst_i = 1'b1;
		{lvl, dbusy, dfail, fm, cap, hc, wreq, flt} = '0;
		for (int r = 0; r < 2; r++) begin
			fn[r] = FUNC_WINDOW;
			lh[r] = 1'b1;
			hi[r] = 16'sh78;
			lo[r] = -16'sh78;
			db[r] = 16'sh14;
			ds[r] = 5'h0;
			fs[r] = r[0];
			{le[r], swr[r], rb[r], fe[r], fp[r]} = 5'h0;
		end
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		cyc(2);
		chk(coil[1], 1'b1);
		foreach (DL[j]) begin
			cfg(FUNC_LIMIT, 100, 0, 10, DL[j], 1'b0);
			go(150, 4 * DL[j] - 6);
			chk(al[0], 1'b0);
			cyc(12);
			chk(al[0], 1'b1);
			chk({coil[0], led[0]}, 2'b11);
			go(95, 30);
			chk(al[0], 1'b1);
			go(90, 4 * DL[j] - 6);
			chk(al[0], 1'b1);
			cyc(12);
			chk({coil[0], led[0]}, 2'b00);
		end
		for (int i = 0; i < 8; i++) begin
			go(i[0] ? 50 : 150, 0);
		end
		chk(al[0], 1'b0);
		@(posedge clk_i);
		lh[0] <= 1'b0;
		cfg(FUNC_LIMIT, 0, -100, 10, 0, 1'b0);
		go(-150, 4);
		chk(al[0], 1'b1);
		go(-95, 4);
		chk(al[0], 1'b1);
		go(-90, 4);
		chk(al[0], 1'b0);
		lh[0] <= 1'b1;
		cfg(FUNC_LIMIT, 100, 0, 10, 1, 1'b1);
		for (int k = 0; k < 2; k++) begin
			go(150, 12);
			rel(1'b1, k);
			cyc(12);
			chk(al[0], 1'b1);
			rel(1'b0, k);
			go(0, 12);
			chk(al[0], 1'b1);
			rel(1'b1, k);
			cyc(8);
			chk(al[0], 1'b0);
			rel(1'b0, k);
		end
		cfg(FUNC_ONOFF, 100, 0, 10, 1, 1'b1);
		go(150, 12);
		chk(al[0], 1'b1);
		go(50, 20);
		chk(al[0], 1'b1);
		go(-10, 12);
		chk(al[0], 1'b0);
		for (int s = 1; s > -2; s -= 2) begin
			cfg(FUNC_PEAK, 100 * s, 0, 10, 3, 1'b0);
			foreach (PV[i]) begin
				go(PV[i] * s, i == 2 ? 24 : i == 0 ? -1 : 2);
				chk(al[0], i == 4 || i == 5);
			end
		end
		cfg(FUNC_ROC, 50, 20, 0, 0, 1'b0);
		for (int i = 0; i < 18; i++) begin
			go((i / 6) % 2 * 100, 2);
			chk(al[0], i > 5 && i % 6 != 5);
		end
		for (int i = 0; i < 46; i++) begin
			go(i < 6 ? CW[i] : $random(seed) % 200, 2);
			chk(al[1], w_exp);
			chk({coil[1], led[1]}, {!w_exp, w_exp});
		end
		look(0, 2'b10);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_i);
			{dbusy, dfail} <= k[0] ? 2'b01 : 2'b10;
			look(0, 2'b11);
		end
		@(posedge clk_i);
		{dfail, cap} <= 2'b01;
		look(1, 2'b01);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_i);
			flt <= 4'h1 << k;
			look(1, 2'b11);
		end
		@(posedge clk_i);
		{flt, cap, fm} <= 6'h01;
		look(0, 2'b01);
		@(posedge clk_i);
		cap <= 1'b1;
		look(1, 2'b11);
		for (int r = 0; r < 2; r++) begin
			@(posedge clk_i);
			fe[r] <= 1'b1;
			fe[1 - r] <= 1'b0;
			look(r + 2, 2'b10);
			look(3 - r, 2'b01);
			@(posedge clk_i);
			fp[r] <= 1'b1;
			look(r + 2, 2'b11);
		end
		for (int k = 0; k < 8; k++) begin
			@(posedge clk_i);
			{fm, hc, wreq} <= k[2:0];
			cyc(1);
			chk(wok, k == 7);
		end
		end_sim();
	end
endmodule : test_relay_alarm_evaluator
